// ### verilog/iss_pkg.sv
// package for the idle sweep scheduler: register map, timing constants, types
// assumes a 200 MHz clock and a classic wishbone master with 32-bit data
package iss_pkg;

    // clock and timing
    localparam int unsigned CLK_HZ           = 200_000_000;
    localparam int unsigned TICK_US          = 1000;
    localparam int unsigned TICK_CYCLES      = CLK_HZ / 1_000_000 * TICK_US;
    localparam int unsigned ARM_TIME_MIN     = 12;
    localparam int unsigned IDLE_TIME_MIN    = 15;
    localparam int unsigned SWEEP_TIME_MS    = 150;
    localparam int unsigned ARM_TICKS        = ARM_TIME_MIN * 60 * 1000 * 1000 / TICK_US;
    localparam int unsigned IDLE_TICKS       = IDLE_TIME_MIN * 60 * 1000 * 1000 / TICK_US;
    localparam int unsigned SWEEP_TICKS      = SWEEP_TIME_MS * 1000 / TICK_US;

    // bus control codes that start a seek
    localparam logic [7:0]  BC_SET_CYLINDER  = 8'h04;
    localparam logic [7:0]  BC_SET_POSITION  = 8'h05;

    // register byte offsets
    localparam logic [3:0]  REG_CONFIG       = 4'h0;
    localparam logic [3:0]  REG_STATUS       = 4'h4;
    localparam logic [3:0]  REG_ADDRESS      = 4'h8;

    // config field positions
    localparam int unsigned CFG_SWEEP_DIS    = 0;
    localparam int unsigned CFG_ON_SEEK      = 1;
    localparam int unsigned CFG_RETURN       = 2;
    localparam int unsigned CFG_RUNT         = 3;
    localparam int unsigned CFG_BOARD_INIT   = 4;
    localparam int unsigned CFG_PANEL        = 5;
    localparam logic [7:0]  CFG_RESET        = 8'h00;
    localparam logic [3:0]  PANEL_ADDR_RESET = 4'h0;

    // status field positions
    localparam int unsigned ST_SWEEP_EN      = 0;
    localparam int unsigned ST_SWEEPING      = 1;
    localparam int unsigned ST_BOARD_SWEEP   = 2;
    localparam int unsigned ST_BUSY          = 3;

    typedef enum logic [1:0] {
        ISS_IDLE,
        ISS_SWEEP,
        ISS_SEEK,
        ISS_RETURN
    } iss_state_type;

    // controller seek request as it arrives from the bus front end
    typedef struct packed {
        logic       valid;
        logic [7:0] code;
        logic       nonzero;
    } iss_seek_req_type;

    // answer to the controller
    typedef struct packed {
        logic done;
        logic busy;
    } iss_seek_rsp_type;

endpackage : iss_pkg

// ### verilog/iss_tick_timer.sv
// down counter of prescaled ticks: load, count, one-cycle expiry pulse
// assumes tick_i is a one-cycle pulse from the same clock
`timescale 1ns/10ps
`default_nettype none
module iss_tick_timer #(
    parameter int unsigned WIDTH = 24
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // control
    input  wire logic             load_i,
    input  wire logic [WIDTH-1:0] count_i,
    input  wire logic             stop_i,
    input  wire logic             tick_i,
    // status
    output logic                  running_o,
    output logic                  expire_o
);
    logic [WIDTH-1:0] count_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i || stop_i) begin
            count_reg <= '0;
            running_o <= 1'b0;
        end else if (load_i) begin
            count_reg <= count_i;
            running_o <= 1'b1;
        end else if (running_o && tick_i) begin
            count_reg <= count_reg - 1'b1;
            if (count_reg == {{(WIDTH-1){1'b0}}, 1'b1})
                running_o <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || stop_i || load_i)
            expire_o <= 1'b0;
        else
            expire_o <= running_o && tick_i && (count_reg == {{(WIDTH-1){1'b0}}, 1'b1});
    end
endmodule : iss_tick_timer
`default_nettype wire

// ### verilog/iss_scheduler.sv
// idle sweep scheduler: arming and idle timers, sweep segments, busy answer
// assumes synchronous controller request ports, async jumpers/switches on pins
// Overview of operation
// - without panel, address comes from four switches, closed reads zero.
// - switches default all closed, so address reads zero.
// - with panel fitted, switches ignored and panel address used.
// - sector switch inputs affect nothing.
// - runt jumper fitted suppresses truncated sector pulses; removed lets them through.
// - sweep-disable jumper stops all sweeps and masks the other sweep jumpers.
// - sweep-on-seek removed: sweep segments launch only with seeks.
// - return-heads removed: no head return after a sweep segment.
// - arming timer of 12 minutes starts on ready after power-on or reset.
// - arming expiry enters sweep-enable until a sweep segment runs.
// - in sweep-enable, first controller seek (codes 04, 05) triggers a sweep.
// - after sweep, seek target, answer, rearm timer, leave sweep-enable.
// - a seek carrying a sweep lasts 150 ms longer.
// - board sweeps disabled: stay sweep-enabled until a controller seek.
// - board sweeps enabled: 15-minute idle timer, expiry issues internal seek.
// - selection during a board sweep is answered busy.
// - board sweep ends with a seek back to the original cylinder.
// - a switch selects whether the board may initiate sweeps.
//
// Decided for this implementation: the address map and the Wishbone slave port.
`timescale 1ns/10ps
`default_nettype none
module iss_scheduler #(
    parameter int unsigned ARM_TICKS   = iss_pkg::ARM_TICKS,
    parameter int unsigned IDLE_TICKS  = iss_pkg::IDLE_TICKS,
    parameter int unsigned TICK_CYCLES = iss_pkg::TICK_CYCLES
) (
    // clock and reset
    input  wire logic                      clk_i,
    input  wire logic                      rst_i,
    // wishbone slave
    input  wire logic                      cyc_i,
    input  wire logic                      stb_i,
    input  wire logic                      we_i,
    input  wire logic [3:0]                adr_i,
    input  wire logic [3:0]                sel_i,
    input  wire logic [31:0]               dat_i,
    output logic      [31:0]               dat_o,
    output logic                           ack_o,
    // board pins (asynchronous)
    input  wire logic                      sweep_disable_jumper_i,
    input  wire logic                      sweep_on_seek_jumper_i,
    input  wire logic                      return_heads_jumper_i,
    input  wire logic                      runt_jumper_i,
    input  wire logic                      board_sweep_switch_i,
    input  wire logic [3:0]                addr_switch_i,
    input  wire logic [3:0]                sector_switch_i,
    input  wire logic                      sector_pulse_i,
    input  wire logic                      sector_runt_i,
    // drive status and controller requests
    input  wire logic                      drive_ready_i,
    input  wire iss_pkg::iss_seek_req_type seek_req_i,
    input  wire logic                      select_i,
    input  wire logic                      seek_done_i,
    // outputs
    output iss_pkg::iss_seek_rsp_type      seek_rsp_o,
    output logic                           mech_seek_o,
    output logic                           mech_sweep_o,
    output logic                           mech_return_o,
    output logic                           sector_pulse_o,
    output logic      [3:0]                logical_addr_o
);
    localparam int unsigned TW = 28;

    // two-stage synchronisers for the pins
    logic [14:0] pin_meta_reg;
    logic [14:0] pin_sync_reg;
    always_ff @(posedge clk_i) begin
        pin_meta_reg <= {sweep_disable_jumper_i, sweep_on_seek_jumper_i, return_heads_jumper_i,
                         runt_jumper_i, board_sweep_switch_i, addr_switch_i, sector_pulse_i,
                         sector_runt_i, sector_switch_i};
        pin_sync_reg <= pin_meta_reg;
    end
    // sector switches are synchronised but never read
    logic       sweep_disable_jumper_s, on_seek_s, return_s, runt_s, board_s, sec_pulse_s, sec_runt_s;
    logic [3:0] addr_sw_s;
    assign sweep_disable_jumper_s      = pin_sync_reg[14];
    assign on_seek_s   = pin_sync_reg[13];
    assign return_s    = pin_sync_reg[12];
    assign runt_s      = pin_sync_reg[11];
    assign board_s     = pin_sync_reg[10];
    assign addr_sw_s   = pin_sync_reg[9:6];
    assign sec_pulse_s = pin_sync_reg[5];
    assign sec_runt_s  = pin_sync_reg[4];

    // software registers
    logic [7:0] cfg_reg;
    logic [3:0] panel_addr_reg;
    logic       wb_hit;
    assign wb_hit = cyc_i && stb_i && !ack_o;

    function automatic logic is_seek_code(input logic [7:0] code);
        return (code == iss_pkg::BC_SET_CYLINDER) || (code == iss_pkg::BC_SET_POSITION);
    endfunction

    // effective configuration: jumper or software override, panel from software only
    logic sweep_off, board_en, panel_on, runt_on;
    assign sweep_off = sweep_disable_jumper_s || cfg_reg[iss_pkg::CFG_SWEEP_DIS];
    assign board_en  = (board_s || cfg_reg[iss_pkg::CFG_BOARD_INIT]) && !sweep_off;
    assign panel_on  = cfg_reg[iss_pkg::CFG_PANEL];
    assign runt_on   = runt_s || cfg_reg[iss_pkg::CFG_RUNT];
    // sweep-on-seek and return-heads are only valid removed; fitted values are
    // reported but never change sequencing
    logic unused_opts;
    assign unused_opts = on_seek_s ^ return_s ^ cfg_reg[iss_pkg::CFG_ON_SEEK] ^ cfg_reg[iss_pkg::CFG_RETURN];

    // prescaled tick
    logic [TW-1:0] presc_reg;
    logic          tick_reg;
    always_ff @(posedge clk_i) begin
        if (rst_i || presc_reg == TW'(TICK_CYCLES - 1)) begin
            presc_reg <= '0;
            tick_reg  <= !rst_i;
        end else begin
            presc_reg <= presc_reg + 1'b1;
            tick_reg  <= 1'b0;
        end
    end

    // ready rising edge starts arming after power-on or reset
    logic ready_reg;
    always_ff @(posedge clk_i) begin
        if (rst_i)
            ready_reg <= 1'b0;
        else
            ready_reg <= drive_ready_i;
    end

    iss_pkg::iss_state_type state_reg;
    logic       sweep_en_reg;
    logic       board_sweep_reg;
    logic       sweep_seg_reg;
    logic       seg_done;
    logic       arm_load, arm_exp, idle_load, idle_exp, idle_run, seg_load, seg_exp;
    logic       ctrl_seek;

    assign ctrl_seek = seek_req_i.valid && is_seek_code(seek_req_i.code);
    assign arm_load  = (drive_ready_i && !ready_reg) || seg_done;
    assign seg_done  = (state_reg == iss_pkg::ISS_SEEK || state_reg == iss_pkg::ISS_RETURN)
                       && seek_done_i && board_sweep_reg == (state_reg == iss_pkg::ISS_RETURN)
                       && mech_sweep_o == 1'b0 && sweep_seg_reg;
    assign idle_load = board_en && (!idle_run || seg_done
                       || (state_reg == iss_pkg::ISS_IDLE && ctrl_seek));
    assign seg_load  = state_reg == iss_pkg::ISS_IDLE && !sweep_off
                       && ((sweep_en_reg && ctrl_seek) || (board_en && idle_exp));

    iss_tick_timer #(.WIDTH(TW)) u_arm (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .load_i    (arm_load),
        .count_i   (TW'(ARM_TICKS)),
        .stop_i    (sweep_off || !drive_ready_i),
        .tick_i    (tick_reg),
        .running_o (),
        .expire_o  (arm_exp)
    );

    iss_tick_timer #(.WIDTH(TW)) u_idle (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .load_i    (idle_load),
        .count_i   (TW'(IDLE_TICKS)),
        .stop_i    (!board_en),
        .tick_i    (tick_reg),
        .running_o (idle_run),
        .expire_o  (idle_exp)
    );

    // sweep segment length, adds the extra seek time
    iss_tick_timer #(.WIDTH(TW)) u_seg (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .load_i    (seg_load),
        .count_i   (TW'(iss_pkg::SWEEP_TICKS)),
        .stop_i    (1'b0),
        .tick_i    (tick_reg),
        .running_o (),
        .expire_o  (seg_exp)
    );

    // sweep-enable: set on arming expiry, kept until a segment
    always_ff @(posedge clk_i) begin
        if (rst_i || sweep_off)
            sweep_en_reg <= 1'b0;
        else if (arm_exp)
            sweep_en_reg <= 1'b1;
        else if (seg_load)
            sweep_en_reg <= 1'b0;
    end

    // sequencing of segment, target seek and board return
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg       <= iss_pkg::ISS_IDLE;
            board_sweep_reg <= 1'b0;
            sweep_seg_reg   <= 1'b0;
            mech_sweep_o    <= 1'b0;
            mech_seek_o     <= 1'b0;
            mech_return_o   <= 1'b0;
        end else begin
            mech_seek_o <= 1'b0;
            case (state_reg)
                iss_pkg::ISS_IDLE: begin
                    if (seg_load) begin
                        state_reg       <= iss_pkg::ISS_SWEEP;
                        board_sweep_reg <= !(sweep_en_reg && ctrl_seek);
                        sweep_seg_reg   <= 1'b1;
                        mech_sweep_o    <= 1'b1;
                    end else if (ctrl_seek) begin
                        state_reg     <= iss_pkg::ISS_SEEK;
                        sweep_seg_reg <= 1'b0;
                        mech_seek_o   <= 1'b1;
                    end
                end
                iss_pkg::ISS_SWEEP: begin
                    if (seg_exp) begin
                        mech_sweep_o <= 1'b0;
                        if (board_sweep_reg) begin
                            state_reg     <= iss_pkg::ISS_RETURN;
                            mech_return_o <= 1'b1;
                        end else begin
                            state_reg   <= iss_pkg::ISS_SEEK;
                            mech_seek_o <= 1'b1;
                        end
                    end
                end
                iss_pkg::ISS_SEEK,
                iss_pkg::ISS_RETURN: begin
                    if (seek_done_i) begin
                        state_reg       <= iss_pkg::ISS_IDLE;
                        mech_return_o   <= 1'b0;
                        board_sweep_reg <= 1'b0;
                        sweep_seg_reg   <= 1'b0;
                    end
                end
                default: begin
                    state_reg <= iss_pkg::ISS_IDLE;
                end
            endcase
        end
    end

    // controller answer: done for its own seeks, busy during a board sweep
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            seek_rsp_o <= '0;
        end else begin
            seek_rsp_o.done <= state_reg == iss_pkg::ISS_SEEK && seek_done_i;
            seek_rsp_o.busy <= select_i && board_sweep_reg
                               && state_reg != iss_pkg::ISS_IDLE;
        end
    end

    // logical address and sector pulse outputs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            logical_addr_o <= 4'h0;
            sector_pulse_o <= 1'b0;
        end else begin
            // open switch reads one, closed reads zero
            logical_addr_o <= panel_on ? panel_addr_reg : addr_sw_s;
            sector_pulse_o <= sec_pulse_s && !(runt_on && sec_runt_s);
        end
    end

    // wishbone register file, single-cycle ack
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_reg        <= iss_pkg::CFG_RESET;
            panel_addr_reg <= iss_pkg::PANEL_ADDR_RESET;
        end else if (cyc_i && stb_i && ack_o && we_i && sel_i[0]) begin
            if (adr_i == iss_pkg::REG_CONFIG)
                cfg_reg <= dat_i[7:0];
            else if (adr_i == iss_pkg::REG_ADDRESS)
                panel_addr_reg <= dat_i[3:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_o <= wb_hit;
            dat_o <= 32'h0000_0000;
            if (wb_hit && !we_i) begin
                case (adr_i)
                    iss_pkg::REG_CONFIG:  dat_o <= {24'h00_0000, cfg_reg};
                    iss_pkg::REG_STATUS:  dat_o <= {16'h0000, 1'b0, unused_opts, sweep_disable_jumper_s, board_s,
                                                    runt_s, on_seek_s, return_s, 1'b0,
                                                    4'h0, seek_rsp_o.busy, board_sweep_reg,
                                                    mech_sweep_o, sweep_en_reg};
                    iss_pkg::REG_ADDRESS: dat_o <= {28'h000_0000, logical_addr_o};
                    default:              dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule : iss_scheduler
`default_nettype wire

// ### testbench/iss_scheduler_checker.sv
// port assertions for the idle sweep scheduler
// assumes pins are held steady for some cycles around each sweep decision
`timescale 1ns/10ps
`default_nettype none
module iss_scheduler_checker #(
    parameter int unsigned ARM_TICKS   = 20,
    parameter int unsigned IDLE_TICKS  = 30,
    parameter int unsigned TICK_CYCLES = 4
) (
    // clock and reset
    input wire logic                      clk_i,
    input wire logic                      rst_i,
    // bus and pins
    input wire logic                      cyc_i,
    input wire logic                      stb_i,
    input wire logic                      ack_o,
    input wire logic                      sweep_disable_jumper_i,
    input wire logic                      board_sweep_switch_i,
    // controller and mechanics
    input wire iss_pkg::iss_seek_req_type seek_req_i,
    input wire logic                      select_i,
    input wire logic                      seek_done_i,
    input wire iss_pkg::iss_seek_rsp_type seek_rsp_o,
    input wire logic                      mech_seek_o,
    input wire logic                      mech_sweep_o,
    input wire logic                      mech_return_o
);
    localparam int SW_MIN = iss_pkg::SWEEP_TICKS * TICK_CYCLES - TICK_CYCLES;
    localparam int SW_MAX = iss_pkg::SWEEP_TICKS * TICK_CYCLES + TICK_CYCLES;
    int sweep_len_reg;
    // tick phase makes the length uncertain by one tick either way
    always_ff @(posedge clk_i) begin
        if (rst_i || !mech_sweep_o)
            sweep_len_reg <= 0;
        else
            sweep_len_reg <= sweep_len_reg + 1;
    end
    ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
        cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o) else $error("bus ack late or long");
    reset_clear_a: assert property (@(posedge clk_i)
        rst_i |=> !mech_sweep_o && !mech_return_o && !mech_seek_o && seek_rsp_o == '0)
        else $error("outputs not cleared by reset");
    sweep_len_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(mech_sweep_o) |-> sweep_len_reg >= SW_MIN && sweep_len_reg <= SW_MAX)
        else $error("sweep segment length wrong");
    after_sweep_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(mech_sweep_o) |-> ##[0:2] (mech_seek_o || mech_return_o)) else $error("no seek after sweep");
    seek_cause_a: assert property (@(posedge clk_i) disable iff (rst_i)
        mech_seek_o |-> $past(mech_sweep_o) || $past(mech_sweep_o, 2) || ($past(seek_req_i.valid)
        && ($past(seek_req_i.code) == iss_pkg::BC_SET_CYLINDER || $past(seek_req_i.code) == iss_pkg::BC_SET_POSITION)))
        else $error("seek without a cause");
    sweep_cause_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(mech_sweep_o) |-> $past(seek_req_i.valid) || $past(board_sweep_switch_i, 4))
        else $error("sweep without seek");
    no_dis_sweep_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(mech_sweep_o) |-> !$past(sweep_disable_jumper_i, 4)) else $error("sweep while disabled");
    return_board_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(mech_return_o) |-> $past(board_sweep_switch_i, 4)) else $error("return outside board sweep");
    busy_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
        select_i && mech_return_o |=> seek_rsp_o.busy) else $error("busy missing");
    busy_cause_a: assert property (@(posedge clk_i) disable iff (rst_i)
        seek_rsp_o.busy |-> $past(select_i)) else $error("busy without selection");
    done_cause_a: assert property (@(posedge clk_i) disable iff (rst_i)
        seek_rsp_o.done |-> $past(seek_done_i) ##1 !seek_rsp_o.done) else $error("done without seek end");
endmodule // iss_scheduler_checker
bind iss_scheduler iss_scheduler_checker #(.ARM_TICKS(ARM_TICKS), .IDLE_TICKS(IDLE_TICKS),
    .TICK_CYCLES(TICK_CYCLES)) u_iss_scheduler_checker (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .ack_o(ack_o), .sweep_disable_jumper_i(sweep_disable_jumper_i),
    .board_sweep_switch_i(board_sweep_switch_i), .seek_req_i(seek_req_i), .select_i(select_i),
    .seek_done_i(seek_done_i), .seek_rsp_o(seek_rsp_o), .mech_seek_o(mech_seek_o),
    .mech_sweep_o(mech_sweep_o), .mech_return_o(mech_return_o));
`default_nettype wire

// ### testbench/iss_ctrl_model.sv
// host controller and mechanics model: seek requests, selection, seek end
// assumes the bench pulses go_i for one cycle per request
`timescale 1ns/10ps
`default_nettype none
module iss_ctrl_model (
    // clock and reset
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    // bench commands
    input  wire logic                 go_i,
    input  wire logic [7:0]           code_i,
    input  wire logic                 sel_req_i,
    input  wire logic                 slow_i,
    // drive side
    input  wire logic                 mech_seek_i,
    input  wire logic                 mech_return_i,
    output iss_pkg::iss_seek_req_type seek_req_o,
    output logic                      select_o,
    output logic                      seek_done_o
);
    logic       ret_d_reg;
    logic [5:0] wait_reg;
    // idle code lines toggle each cycle between the last code and its inverse
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            seek_req_o <= '0;
            select_o   <= 1'b0;
        end else begin
            seek_req_o.valid   <= go_i;
            seek_req_o.code    <= go_i ? code_i : ~seek_req_o.code;
            seek_req_o.nonzero <= 1'b1;
            select_o           <= sel_req_i;
        end
    end
    // mechanics end a seek or return a short or a long while after start
    always_ff @(posedge clk_i) begin
        ret_d_reg   <= mech_return_i;
        seek_done_o <= !rst_i && wait_reg == 6'h01;
        if (rst_i)
            wait_reg <= 6'h00;
        else if (mech_seek_i || (mech_return_i && !ret_d_reg))
            wait_reg <= slow_i ? 6'h14 : 6'h03;
        else if (wait_reg != 6'h00)
            wait_reg <= wait_reg - 6'h01;
    end
endmodule // iss_ctrl_model
`default_nettype wire

// ### testbench/tb.sv
// self-checking bench for the idle sweep scheduler
// assumes timers shrunk to 20 and 30 ticks of 4 cycles
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic                      clk, rst, cyc, stb, we, sdis, sos, rtn, runt, bsw, spul, srunt, rdy;
    logic                      go, selq, slow, ack, mseek, msweep, mret, spo, sdone, select;
    logic [3:0]                adr, sel, asw, ssw, laddr;
    logic [7:0]                code;
    logic [31:0]               dat, rdat;
    iss_pkg::iss_seek_req_type req;
    iss_pkg::iss_seek_rsp_type rsp;
    int                        seed = 35527, bad_count = 0, checked = 0, nsw = 0, npul = 0;
    logic [31:0]               exp_q[$], msk_q[$];

    iss_scheduler #(.ARM_TICKS(20), .IDLE_TICKS(30), .TICK_CYCLES(4)) u_iss_scheduler (
        .clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
        .dat_i(dat), .dat_o(rdat), .ack_o(ack), .sweep_disable_jumper_i(sdis),
        .sweep_on_seek_jumper_i(sos), .return_heads_jumper_i(rtn), .runt_jumper_i(runt),
        .board_sweep_switch_i(bsw), .addr_switch_i(asw), .sector_switch_i(ssw),
        .sector_pulse_i(spul), .sector_runt_i(srunt), .drive_ready_i(rdy), .seek_req_i(req),
        .select_i(select), .seek_done_i(sdone), .seek_rsp_o(rsp), .mech_seek_o(mseek),
        .mech_sweep_o(msweep), .mech_return_o(mret), .sector_pulse_o(spo), .logical_addr_o(laddr));
    iss_ctrl_model u_iss_ctrl_model (.clk_i(clk), .rst_i(rst), .go_i(go), .code_i(code),
        .sel_req_i(selq), .slow_i(slow), .mech_seek_i(mseek), .mech_return_i(mret),
        .seek_req_o(req), .select_o(select), .seek_done_o(sdone));

    always #2.5 clk = ~clk;
    always @(posedge msweep) nsw++;
    always @(posedge clk) npul += spo;

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            bad_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // reads note the expected value; the monitor below compares at ack
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, e, m);
        @(posedge clk);
        {cyc, stb, we, adr, dat, sel} <= {1'b1, 1'b1, w, a, d, 4'hf};
        if (!w) begin
            exp_q.push_back(e);
            msk_q.push_back(m);
        end
        @(posedge clk);
        while (ack !== 1'b1)
            @(posedge clk);
        {cyc, stb} <= 2'b00;
    endtask

    always @(posedge clk) begin
        if (ack === 1'b1 && we === 1'b0)
            chk(rdat & msk_q.pop_front(), exp_q.pop_front());
    end

    function automatic logic pick(input int k);
        case (k)
            0: return msweep;
            1: return mret;
            2: return rsp.done;
            3: return mseek;
            default: return !mret;
        endcase
    endfunction

    task automatic wait_on(input int k, input int lim);
        int n;
        n = 0;
        while (pick(k) !== 1'b1 && n < lim) begin
            @(posedge clk);
            n++;
        end
        chk(pick(k), 1'b1);
    endtask

    task automatic seek(input logic [7:0] c);
        @(posedge clk);
        {go, code} <= {1'b1, c};
        @(posedge clk);
        go <= 1'b0;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        give_verdict();
    end

    initial begin
        clk = 1'b0;
        rst = 1'b1;
        {cyc, stb, we, sdis, sos, rtn, runt, bsw, spul, srunt, rdy, go, selq, slow} = '0;
        {adr, sel, asw, ssw, code, dat} = '0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        chk(laddr, 4'h0);
        wb(0, iss_pkg::REG_CONFIG, 0, 32'h0000_0000, 32'h0000_00ff);
        wb(1, 4'hc, $random(seed), 0, 0);
        wb(0, 4'hc, 0, 32'h0000_0000, 32'hffff_ffff);
        for (int i = 0; i < 8; i++) begin
            asw <= i[3:0];
            ssw <= 4'($random(seed));
            repeat (4) @(posedge clk);
            chk(laddr, i[3:0]);
            wb(0, iss_pkg::REG_ADDRESS, 0, i, 32'h0000_000f);
        end
        wb(1, iss_pkg::REG_CONFIG, 32'h0000_0020, 0, 0);
        wb(1, iss_pkg::REG_ADDRESS, 32'h0000_0005, 0, 0);
        wb(0, iss_pkg::REG_ADDRESS, 0, 32'h0000_0005, 32'h0000_000f);
        wb(1, iss_pkg::REG_CONFIG, 32'h0000_0000, 0, 0);
        for (int j = 0; j < 2; j++) begin
            runt <= !j[0];
            repeat (4) @(posedge clk);
            npul = 0;
            {spul, srunt} <= 2'b11;
            repeat (3) @(posedge clk);
            {spul, srunt} <= 2'b00;
            repeat (8) @(posedge clk);
            chk(npul != 0, j[0]);
        end
        rdy <= 1'b1;
        repeat (40) @(posedge clk);
        wb(0, iss_pkg::REG_STATUS, 0, 0, 1);
        repeat (100) @(posedge clk);
        wb(0, iss_pkg::REG_STATUS, 0, 1, 1);
        slow <= 1'b1;
        seek(iss_pkg::BC_SET_CYLINDER);
        wait_on(0, 10);
        wait_on(2, 900);
        wb(0, iss_pkg::REG_STATUS, 0, 0, 1);
        slow <= 1'b0;
        seek(iss_pkg::BC_SET_POSITION);
        wait_on(3, 10);
        wait_on(2, 100);
        seek(8'h06);
        repeat (300) @(posedge clk);
        chk(nsw, 1);
        wb(0, iss_pkg::REG_STATUS, 0, 1, 1);
        sdis <= 1'b1;
        repeat (4) @(posedge clk);
        seek(iss_pkg::BC_SET_CYLINDER);
        wait_on(2, 100);
        chk(nsw, 1);
        {sdis, bsw, slow} <= 3'b011;
        wait_on(0, 2000);
        selq <= 1'b1;
        wait_on(1, 800);
        repeat (2) @(posedge clk);
        chk(rsp.busy, 1'b1);
        wait_on(4, 100);
        {selq, bsw} <= 2'b00;
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        wb(0, iss_pkg::REG_STATUS, 0, 0, 1);
        chk(msweep, 1'b0);
        give_verdict();
    end
endmodule // tb
`default_nettype wire
